// ===== design/ram_regs.sv
// Summary of operation
// [R1] clamp dfe taps 2-5 to 4-bit limit
// [R2] clamp dfe tap 1 to 5-bit limit
// [R3] ppm trigger starts count, self-clears
// [R4] cap dac uses override range when enabled
// [R5] ctle starts at index when enabled
// [R6] fixed boost per stage at divide 4/8
// [R7] eye monitoring only after lock declared
// [R8] repeat eye measurement once per interval
// [R9] eye openings compared to threshold times four
// [R10] status and count registers read-only
// [R11] eye interrupt only when enable bit set
`timescale 1ns/100ps
`default_nettype none
module ram_regs #(
  parameter int UNIT_CYC = ram_pkg::RAM_INTERVAL_UNIT_CYC
) (
  // clock, reset, enable
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       clk_en,
  // register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // adaptation engine
  input  wire logic [5:0] tap1_raw,
  input  wire logic [4:0] tap_raw [4],
  output logic      [5:0] tap1_clamped,
  output logic      [4:0] tap_clamped [4],
  input  wire logic [7:0] ctle_state_readback,
  input  wire logic [7:0] dfe_state_readback,
  input  wire logic       adapt_start_en,
  output logic            ctle_start_valid,
  output logic      [4:0] ctle_start_idx,
  input  wire logic       low_divide,
  output logic      [1:0] boost_stage [4],
  output logic            boost_fixed,
  // capacitor dac
  input  wire logic [1:0] cap_range_auto,
  output logic      [1:0] cap_range,
  // frequency error counter
  output logic            ppm_start,
  input  wire logic       ppm_done,
  input  wire logic [15:0] frequency_error_count,
  // eye monitor
  input  wire logic       lock_detect_logic,
  input  wire logic       adapt_done,
  output logic            eye_measure,
  input  wire logic       eye_done,
  input  wire logic [7:0] horizontal_eye_opening,
  input  wire logic [7:0] vertical_eye_opening,
  output logic            eye_irq
);
  import ram_pkg::*;

  logic [7:0] lim_q, lim_d, t1_q, t1_d, cap_q, cap_d, idx_q, idx_d;
  logic [7:0] bst_q, bst_d, mon_q, mon_d, thr_q, thr_d, ivl_q, ivl_d;
  logic [7:0] spr_q, spr_d, cst_q, cst_d, dst_q, dst_d;
  logic [15:0] ppm_q, ppm_d;
  logic        go_q, go_d;
  ram_eye_t    st_q, st_d;
  logic [15:0] unit_q, unit_d;
  logic [3:0]  ivc_q, ivc_d;
  logic        irq_q, irq_d;
  logic        ms_q, ms_d;

  function automatic logic wr_hit(input logic [7:0] a);
    return reg_wr && reg_addr == a;
  endfunction

  // saturating magnitude clamp, sign kept in msb
  function automatic logic [5:0] clamp(input logic [5:0] v,
                                       input logic [4:0] lim);
    logic [4:0] mag;
    mag = v[4:0];
    if (mag > lim) mag = lim;
    return {v[5], mag};
  endfunction

  always_comb begin
    lim_d = lim_q;
    t1_d  = t1_q;
    cap_d = cap_q;
    idx_d = idx_q;
    bst_d = bst_q;
    mon_d = mon_q;
    thr_d = thr_q;
    ivl_d = ivl_q;
    spr_d = spr_q;
    cst_d = ctle_state_readback;
    dst_d = dfe_state_readback;
    ppm_d = ppm_q;
    go_d  = go_q;
    if (wr_hit(RAM_OFF_TAP_LIMITS)) lim_d = {4'h0, reg_wdata[3:0]};
    if (wr_hit(RAM_OFF_TAP1_PPM)) begin
      t1_d = {3'h0, reg_wdata[4:0]};
      if (reg_wdata[RAM_BIT_PPM_GO]) go_d = 1'b1; // R3
    end
    if (wr_hit(RAM_OFF_CAPDAC))    cap_d = reg_wdata;
    if (wr_hit(RAM_OFF_START_IDX)) idx_d = reg_wdata;
    if (wr_hit(RAM_OFF_BOOST))     bst_d = reg_wdata;
    if (wr_hit(RAM_OFF_EYE_MON))   mon_d = {reg_wdata[7], 7'h00};
    if (wr_hit(RAM_OFF_EYE_THR))   thr_d = reg_wdata;
    if (wr_hit(RAM_OFF_INTERVAL))  ivl_d = {4'h0, reg_wdata[3:0]};
    if (wr_hit(RAM_OFF_SPARE))     spr_d = reg_wdata;
    // status and count offsets take no write
    // a fresh trigger in the done cycle wins over the self clear
    if (go_q && ppm_done) begin
      go_d  = wr_hit(RAM_OFF_TAP1_PPM) && reg_wdata[RAM_BIT_PPM_GO]; // R3
      ppm_d = frequency_error_count; // R3
    end
  end

  // eye monitor sequencer
  always_comb begin
    st_d   = st_q;
    unit_d = unit_q;
    ivc_d  = ivc_q;
    ms_d   = 1'b0;
    irq_d  = irq_q;
    if (!mon_q[RAM_BIT_MON_EN] || !lock_detect_logic) begin
      st_d = RAM_EYE_IDLE; // R7
    end else begin
      case (st_q)
        RAM_EYE_IDLE: st_d = RAM_EYE_WAIT; // R7
        RAM_EYE_WAIT: if (adapt_done) begin
          st_d = RAM_EYE_MEASURE;
          ms_d = 1'b1;
        end
        RAM_EYE_MEASURE: if (eye_done) begin
          // R9
          irq_d = cap_q[RAM_BIT_EYE_IRQ_EN] && // R11
                  (horizontal_eye_opening < {2'b00, thr_q[7:4], 2'b00}
                   || vertical_eye_opening < {2'b00, thr_q[3:0], 2'b00});
          st_d   = RAM_EYE_HOLD;
          unit_d = 16'h0000;
          ivc_d  = 4'h0;
        end
        RAM_EYE_HOLD: begin
          // R8
          if (unit_q == 16'(UNIT_CYC - 1)) begin
            unit_d = 16'h0000;
            if (ivc_q >= ivl_q[3:0]) begin
              st_d = RAM_EYE_MEASURE;
              ms_d = 1'b1;
            end else begin
              ivc_d = ivc_q + 4'h1;
            end
          end else begin
            unit_d = unit_q + 16'h0001;
          end
        end
        default: st_d = RAM_EYE_IDLE;
      endcase
    end
    if (!cap_q[RAM_BIT_EYE_IRQ_EN]) irq_d = 1'b0; // R11
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      lim_q  <= RAM_RST_TAP_LIMITS;
      t1_q   <= RAM_RST_TAP1_PPM;
      cap_q  <= RAM_RST_CAPDAC;
      idx_q  <= RAM_RST_ZERO;
      bst_q  <= RAM_RST_ZERO;
      mon_q  <= RAM_RST_EYE_MON;
      thr_q  <= RAM_RST_EYE_THR;
      ivl_q  <= RAM_RST_INTERVAL;
      spr_q  <= RAM_RST_ZERO;
      cst_q  <= RAM_RST_ZERO;
      dst_q  <= RAM_RST_ZERO;
      ppm_q  <= 16'h0000;
      go_q   <= 1'b0;
      st_q   <= RAM_EYE_IDLE;
      unit_q <= 16'h0000;
      ivc_q  <= 4'h0;
      irq_q  <= 1'b0;
      ms_q   <= 1'b0;
    end else if (clk_en) begin
      lim_q  <= lim_d;
      t1_q   <= t1_d;
      cap_q  <= cap_d;
      idx_q  <= idx_d;
      bst_q  <= bst_d;
      mon_q  <= mon_d;
      thr_q  <= thr_d;
      ivl_q  <= ivl_d;
      spr_q  <= spr_d;
      cst_q  <= cst_d;
      dst_q  <= dst_d;
      ppm_q  <= ppm_d;
      go_q   <= go_d;
      st_q   <= st_d;
      unit_q <= unit_d;
      ivc_q  <= ivc_d;
      irq_q  <= irq_d;
      ms_q   <= ms_d;
    end
  end

  // read mux; status and counts only observable here
  always_comb begin
    case (reg_addr)
      RAM_OFF_TAP_LIMITS: reg_rdata = lim_q;
      RAM_OFF_TAP1_PPM:   reg_rdata = {2'b00, go_q, t1_q[4:0]};
      RAM_OFF_CAPDAC:     reg_rdata = cap_q;
      RAM_OFF_CTLE_STAT:  reg_rdata = cst_q; // R10
      RAM_OFF_DFE_STAT:   reg_rdata = dst_q; // R10
      RAM_OFF_START_IDX:  reg_rdata = idx_q;
      RAM_OFF_BOOST:      reg_rdata = bst_q;
      RAM_OFF_PPM_HI:     reg_rdata = ppm_q[15:8]; // R10
      RAM_OFF_PPM_LO:     reg_rdata = ppm_q[7:0]; // R10
      RAM_OFF_SPARE:      reg_rdata = spr_q;
      RAM_OFF_EYE_MON:    reg_rdata = mon_q;
      RAM_OFF_EYE_THR:    reg_rdata = thr_q;
      RAM_OFF_INTERVAL:   reg_rdata = ivl_q;
      default:            reg_rdata = 8'h00;
    endcase
  end

  assign tap1_clamped = clamp(tap1_raw, t1_q[4:0]); // R2
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_tap
      logic [5:0] c;
      // limit is only 4 bits wide, so extend with zero
      assign c = clamp({tap_raw[gi][4], 1'b0, tap_raw[gi][3:0]},
                       {1'b0, lim_q[3:0]}); // R1
      assign tap_clamped[gi] = {c[5], c[3:0]};
      assign boost_stage[gi] = bst_q[7 - 2*gi -: 2]; // R6
    end
  endgenerate
  assign boost_fixed      = low_divide; // R6
  assign cap_range        = cap_q[RAM_BIT_CAP_OVR] ? cap_q[1:0]
                                                    : cap_range_auto; // R4
  assign ctle_start_valid = adapt_start_en; // R5
  assign ctle_start_idx   = adapt_start_en ? idx_q[4:0] : 5'h00; // R5
  assign ppm_start        = go_q; // R3
  assign eye_measure      = ms_q; // R8
  assign eye_irq          = irq_q; // R11
endmodule
`default_nettype wire

// ===== design/ram_pkg.sv
`default_nettype none
package ram_pkg;
  localparam logic [7:0] RAM_OFF_TAP_LIMITS = 8'h34;
  localparam logic [7:0] RAM_OFF_TAP1_PPM   = 8'h35;
  localparam logic [7:0] RAM_OFF_CAPDAC     = 8'h36;
  localparam logic [7:0] RAM_OFF_CTLE_STAT  = 8'h37;
  localparam logic [7:0] RAM_OFF_DFE_STAT   = 8'h38;
  localparam logic [7:0] RAM_OFF_START_IDX  = 8'h39;
  localparam logic [7:0] RAM_OFF_BOOST      = 8'h3a;
  localparam logic [7:0] RAM_OFF_PPM_HI     = 8'h3b;
  localparam logic [7:0] RAM_OFF_PPM_LO     = 8'h3c;
  localparam logic [7:0] RAM_OFF_SPARE      = 8'h3d;
  localparam logic [7:0] RAM_OFF_EYE_MON    = 8'h3e;
  localparam logic [7:0] RAM_OFF_EYE_THR    = 8'h32;
  localparam logic [7:0] RAM_OFF_INTERVAL   = 8'h69;
  localparam logic [7:0] RAM_RST_TAP_LIMITS = 8'h0f;
  localparam logic [7:0] RAM_RST_TAP1_PPM   = 8'h1f;
  localparam logic [7:0] RAM_RST_CAPDAC     = 8'h31;
  localparam logic [7:0] RAM_RST_EYE_MON    = 8'h80;
  localparam logic [7:0] RAM_RST_EYE_THR    = 8'h11;
  localparam logic [7:0] RAM_RST_INTERVAL   = 8'h00;
  localparam logic [7:0] RAM_RST_ZERO       = 8'h00;
  localparam int RAM_BIT_PPM_GO     = 5;
  localparam int RAM_BIT_EYE_IRQ_EN = 6;
  localparam int RAM_BIT_CAP_OVR    = 2;
  localparam int RAM_BIT_START_EN   = 3;
  localparam int RAM_BIT_MON_EN     = 7;
  localparam int RAM_THR_SHIFT      = 2;
  // eye interval unit in core cycles: 100 us at 20 MHz
  localparam int RAM_INTERVAL_UNIT_NS = 100000;
  localparam int RAM_CLK_NS           = 50;
  localparam int RAM_INTERVAL_UNIT_CYC = RAM_INTERVAL_UNIT_NS / RAM_CLK_NS;
  typedef enum logic [1:0] {
    RAM_EYE_IDLE    = 2'b00,
    RAM_EYE_WAIT    = 2'b01,
    RAM_EYE_MEASURE = 2'b10,
    RAM_EYE_HOLD    = 2'b11
  } ram_eye_t;
endpackage
`default_nettype wire

// ===== sim/ram_engine_model.sv
`timescale 1ns/100ps
`default_nettype none
module ram_engine_model (
  // clock
  input  wire logic        core_clk,
  // requests
  input  wire logic        ppm_start,
  input  wire logic        eye_measure,
  // answers
  output logic             ppm_done,
  output logic      [15:0] frequency_error_count,
  output logic             eye_done,
  output logic      [7:0]  horizontal_eye_opening,
  output logic      [7:0]  vertical_eye_opening
);
  logic [3:0] cnt_q = 4'h0;
  logic [2:0] eye_q = 3'h0;
  initial ppm_done = 1'b0;
  // values only hold while done is up
  always @(posedge core_clk) begin
    cnt_q    <= (ppm_start && !ppm_done) ? cnt_q + 4'h1 : 4'h0;
    ppm_done <= ppm_start && !ppm_done && cnt_q == 4'h6;
    eye_q    <= {eye_q[1:0], eye_measure};
  end
  assign frequency_error_count = ppm_done ? 16'ha55c : 16'h5aa3;
  assign eye_done = eye_q[2];
  assign horizontal_eye_opening = eye_done ? 8'h03 : 8'hfc;
  assign vertical_eye_opening = eye_done ? 8'h40 : 8'hbf;
endmodule
`default_nettype wire

// ===== sim/ram_regs_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ram_regs_checker
  import ram_pkg::*;
(
  // watched ports
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] tap1_raw,
  input wire logic [5:0] tap1_clamped,
  input wire logic       adapt_start_en,
  input wire logic [4:0] ctle_start_idx,
  input wire logic [1:0] cap_range_auto,
  input wire logic [1:0] cap_range,
  input wire logic       ppm_start,
  input wire logic       ppm_done,
  input wire logic       lock_detect_logic,
  input wire logic       eye_measure,
  input wire logic       eye_done,
  input wire logic       eye_irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_tap1;
    reg_addr == RAM_OFF_TAP1_PPM |-> tap1_clamped == {tap1_raw[5],
      (tap1_raw[4:0] < reg_rdata[4:0] ? tap1_raw[4:0] : reg_rdata[4:0])};
  endproperty
  a_tap1: assert property (p_tap1) else $error("tap1 clamp");
  property p_cap;
    reg_addr == RAM_OFF_CAPDAC |-> cap_range ==
      (reg_rdata[RAM_BIT_CAP_OVR] ? reg_rdata[1:0] : cap_range_auto);
  endproperty
  a_cap: assert property (p_cap) else $error("cap range");
  property p_idx;
    reg_addr == RAM_OFF_START_IDX |-> ctle_start_idx ==
      (adapt_start_en ? reg_rdata[4:0] : 5'h00);
  endproperty
  a_idx: assert property (p_idx) else $error("start index");
  property p_go;
    $rose(ppm_start) |-> $past(reg_wr && reg_wdata[RAM_BIT_PPM_GO]
      && reg_addr == RAM_OFF_TAP1_PPM);
  endproperty
  a_go: assert property (p_go) else $error("ppm start cause");
  property p_clr;
    clk_en && ppm_start && ppm_done && !(reg_wr
      && reg_addr == RAM_OFF_TAP1_PPM && reg_wdata[RAM_BIT_PPM_GO])
      |=> !ppm_start;
  endproperty
  a_clr: assert property (p_clr) else $error("ppm self clear");
  property p_lock;
    eye_measure |-> $past(lock_detect_logic);
  endproperty
  a_lock: assert property (p_lock) else $error("eye before lock");
  // shortest interval is one unit, four cycles of the scaled count
  property p_gap;
    eye_done |=> !eye_measure [*3];
  endproperty
  a_gap: assert property (p_gap) else $error("eye interval");
  property p_irq;
    $rose(eye_irq) |-> $past(eye_done);
  endproperty
  a_irq: assert property (p_irq) else $error("irq cause");
endmodule
bind ram_regs ram_regs_checker i_chk (.*);
`default_nettype wire

// ===== sim/retimer_adapt_monitor_regs_tb.sv
`timescale 1ns/100ps
`default_nettype none
module retimer_adapt_monitor_regs_tb;
  import ram_pkg::*;
  typedef struct {logic [7:0] a, r, w, e;} ram_row_t;
  logic core_clk = 0, reset = 1, clk_en = 1, reg_wr = 0, ppm_done;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, ctle_state_readback = 0;
  logic [7:0] dfe_state_readback = 0, horizontal_eye_opening, vertical_eye_opening;
  logic [5:0] tap1_raw = 0, tap1_clamped;
  logic [4:0] tap_raw [4] = '{default: 0}, tap_clamped [4], ctle_start_idx;
  logic adapt_start_en = 0, low_divide = 0, lock_detect_logic = 0;
  logic adapt_done = 0, eye_done, eye_measure, eye_irq, ppm_start;
  logic ctle_start_valid, boost_fixed;
  logic [1:0] boost_stage [4], cap_range, cap_range_auto = 2'h1;
  logic [15:0] frequency_error_count;
  int fails = 0, num_checks = 0;
  ram_row_t rows [11] = '{'{8'h34, 8'h0f, 8'h05, 8'h05},
    '{8'h35, 8'h1f, 8'h0a, 8'h0a}, '{8'h36, 8'h31, 8'h46, 8'h46},
    '{8'h37, 8'h00, 8'hff, 8'h00}, '{8'h38, 8'h00, 8'hff, 8'h00},
    '{8'h39, 8'h00, 8'h1a, 8'h1a}, '{8'h3a, 8'h00, 8'he4, 8'he4},
    '{8'h3b, 8'h00, 8'hff, 8'h00}, '{8'h3c, 8'h00, 8'h55, 8'h00},
    '{8'h3e, 8'h80, 8'h80, 8'h80}, '{8'h32, 8'h11, 8'h11, 8'h11}};
  ram_regs #(.UNIT_CYC(4)) i_dut (.*);
  ram_engine_model i_eng (.*);
  always #25 core_clk = ~core_clk;
  task automatic test_done;
    if (fails == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge core_clk);
    reg_addr <= a;
    #1 chk("rdata", 16'(reg_rdata), 16'(e));
  endtask
  // bounded wait, sampled after the edge has settled
  task automatic hold(ref logic s);
    int n;
    for (n = 0; s !== 1'b1 && n < 200; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (s !== 1'b1) begin
      fails++;
      test_done();
    end
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i].a, rows[i].r);
      wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].e);
    end
    @(posedge core_clk);
    tap1_raw <= 6'h3f;
    tap_raw[1] <= 5'h1f;
    low_divide <= 1'b1;
    adapt_start_en <= 1'b1;
    #1;
    @(posedge core_clk);
    #1 chk("tap1", 16'(tap1_clamped), 16'h002a);
    chk("tap", 16'(tap_clamped[1]), 16'h0015);
    chk("cap", 16'(cap_range), 16'h0002);
    chk("idx", 16'({ctle_start_valid, ctle_start_idx}), 16'h003a);
    chk("boost", 16'({boost_fixed, boost_stage[0], boost_stage[1],
      boost_stage[2], boost_stage[3]}), 16'h01e4);
    wr(RAM_OFF_TAP1_PPM, 8'h2a);
    hold(ppm_done);
    rd(RAM_OFF_PPM_HI, 8'ha5);
    rd(RAM_OFF_PPM_LO, 8'h5c);
    rd(RAM_OFF_TAP1_PPM, 8'h0a);
    @(posedge core_clk);
    lock_detect_logic <= 1'b1;
    adapt_done <= 1'b1;
    hold(eye_measure);
    hold(eye_done);
    @(posedge core_clk);
    #1 chk("irq", 16'(eye_irq), 16'h0001);
    wr(RAM_OFF_EYE_THR, 8'h01);
    hold(eye_measure);
    hold(eye_done);
    @(posedge core_clk);
    #1 chk("irq", 16'(eye_irq), 16'h0000);
    // nothing lands while the clock enable is low
    @(posedge core_clk);
    clk_en <= 1'b0;
    wr(RAM_OFF_BOOST, 8'h00);
    rd(RAM_OFF_BOOST, 8'he4);
    @(posedge core_clk);
    clk_en <= 1'b1;
    ctle_state_readback <= 8'h5a;
    dfe_state_readback <= 8'ha5;
    rd(RAM_OFF_CTLE_STAT, 8'h5a);
    rd(RAM_OFF_DFE_STAT, 8'ha5);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd(RAM_OFF_CAPDAC, 8'h31);
    test_done();
  end
endmodule
`default_nettype wire
